// ==== rtl/vfs_pkg.sv ====
// Constants and types for the virtual freewheel scroll block
package vfs_pkg;
	localparam int COUNT_W = 16;
	localparam int SPEED_W = 16;
	localparam int BETA_W = 4;
	localparam int PHASE_W = 16;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [SPEED_W-1:0] SPEED_RESET = 16'h0000;
	localparam logic [PHASE_W-1:0] PHASE_RESET = 16'h0000;
	localparam logic [1:0] QUAD_RESET = 2'h0;
	localparam logic [BETA_W-1:0] BETA_MAX = 4'hF;
	localparam int RESET_SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		VFS_IDLE = 2'b00,
		VFS_TOUCHED = 2'b01,
		VFS_FREEWHEEL = 2'b10
	} vfs_state_type;
endpackage : vfs_pkg

// ==== rtl/vfs_avg_filter.sv ====
// Beta filter used for the long-term average of touch counts
module vfs_avg_filter
	import vfs_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_step,
	input wire logic i_freeze,
	input wire logic [WIDTH-1:0] i_sample,
	input wire logic [BETA_W-1:0] i_beta,
	output logic [WIDTH-1:0] o_average
);
	localparam int FRAC = int'(BETA_MAX);
	logic [WIDTH+FRAC:0] acc;
	logic [WIDTH+FRAC:0] next_acc;
	logic [WIDTH+FRAC:0] sample_ext;
	logic [WIDTH+FRAC:0] acc_now;

	always_comb begin
		sample_ext = {{(FRAC+1){1'b0}}, i_sample} << (BETA_MAX - i_beta);
		acc_now = acc >> i_beta;
		next_acc = acc;
		// Fixed scale: output independent of beta, no loop through beta
		if (i_step && !i_freeze) begin
			next_acc = acc - acc_now + sample_ext;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc <= '0;
		end else begin
			acc <= next_acc;
		end
	end

	always_comb begin
		o_average = acc[WIDTH+FRAC-1:FRAC];
	end
endmodule : vfs_avg_filter

// ==== rtl/vfs_freewheel.sv ====
// Virtual freewheel scroll: release detect, simulated speed, pulse output
//
// Overview of operation
// - Count rise or large delta means release
// - Keep intervals and quadrature running while freewheeling
// - Simulated speed decays gradually over time
// - Touch during freewheel stops it immediately
// - Freewheel enable forces two-way touch sensing
// - Release mode never freezes the average
// - Direction flag set when counts below average
// - Start only above minimum start speed
// - Load simulated speed with magnet speed
// - Decay set by inertia, friction, damping
// - Stop once speed below stop threshold
// - Release mode mixes slow and fast coefficients
// - Freewheel uses its own touch thresholds
// - Release threshold chosen by rotation direction
// - Delta above stop threshold halts freewheel
module vfs_freewheel
	import vfs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_sense_step,
	input wire logic [vfs_pkg::COUNT_W-1:0] i_touch_counts,
	input wire logic [vfs_pkg::SPEED_W-1:0] i_magnet_speed,
	input wire logic i_magnet_reverse,
	input wire logic i_magnet_interval,
	input wire logic i_freewheel_enable,
	input wire logic i_forced_hall_freewheel,
	input wire logic i_release_detect_mode,
	input wire logic i_two_way_touch_sensing,
	input wire logic [vfs_pkg::BETA_W-1:0] i_slow_average_coefficient,
	input wire logic [vfs_pkg::BETA_W-1:0] i_fast_average_coefficient,
	input wire logic [vfs_pkg::COUNT_W-1:0] i_touch_threshold,
	input wire logic [vfs_pkg::COUNT_W-1:0] i_forward_release_threshold,
	input wire logic [vfs_pkg::COUNT_W-1:0] i_reverse_release_threshold,
	input wire logic [vfs_pkg::COUNT_W-1:0] i_stop_touch_threshold,
	input wire logic [vfs_pkg::SPEED_W-1:0] i_min_start_speed,
	input wire logic [vfs_pkg::SPEED_W-1:0] i_stop_speed,
	input wire logic [vfs_pkg::BETA_W-1:0] i_inertia,
	input wire logic [vfs_pkg::SPEED_W-1:0] i_friction,
	input wire logic [vfs_pkg::BETA_W-1:0] i_damping,
	output logic [vfs_pkg::COUNT_W-1:0] o_long_term_average,
	output logic o_touch_direction,
	output logic o_touch_active,
	output logic o_release_event,
	output logic o_two_way_active,
	output logic o_freewheel_active,
	output logic [vfs_pkg::SPEED_W-1:0] o_freewheel_speed,
	output logic o_interval_pulse,
	output logic o_interval_reverse,
	output logic [1:0] o_quadrature
);
	logic [RESET_SYNC_STAGES-1:0] rst_sync;
	logic rst_n;
	logic fw_mode;
	logic [COUNT_W-1:0] avg;
	logic freeze;
	logic [BETA_W-1:0] beta;
	logic [COUNT_W:0] delta_up;
	logic [COUNT_W:0] delta_down;
	logic [COUNT_W-1:0] release_thr;
	logic [COUNT_W-1:0] touch_thr;
	logic release_hit;
	logic touch_hit;
	vfs_state_type state;
	vfs_state_type next_state;
	logic [SPEED_W-1:0] speed;
	logic [SPEED_W-1:0] next_speed;
	logic direction_rev;
	logic next_direction_rev;
	logic fast_phase;
	logic next_fast_phase;
	logic [PHASE_W-1:0] phase;
	logic [PHASE_W-1:0] next_phase;
	logic [PHASE_W:0] phase_sum;
	logic [SPEED_W:0] decay;
	logic [SPEED_W+1:0] decay_total;
	logic touch_dir;
	logic next_touch_dir;
	logic touch_act;
	logic next_touch_act;
	logic rel_evt;
	logic next_rel_evt;
	logic int_pulse;
	logic next_int_pulse;
	logic int_rev;
	logic next_int_rev;
	logic [1:0] quad;
	logic [1:0] next_quad;
	logic [COUNT_W-1:0] prev_counts;
	logic [COUNT_W-1:0] next_prev_counts;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_sync <= '0;
		end else begin
			rst_sync <= {rst_sync[RESET_SYNC_STAGES-2:0], 1'b1};
		end
	end
	assign rst_n = rst_sync[RESET_SYNC_STAGES-1];

	// Freewheel configuration as a whole
	assign fw_mode = i_freewheel_enable && i_forced_hall_freewheel
		&& i_release_detect_mode;
	assign o_two_way_active = i_two_way_touch_sensing
		|| i_freewheel_enable;

	// Average runs through touch in release mode
	assign freeze = !i_release_detect_mode && touch_act;
	always_comb begin
		// Release mode: slow by default, fast after touch or release; otherwise fast while counts above average
		if (i_release_detect_mode) begin
			beta = fast_phase ? i_fast_average_coefficient
				: i_slow_average_coefficient;
		end else if (i_touch_counts > avg) begin
			beta = i_fast_average_coefficient;
		end else begin
			beta = i_slow_average_coefficient;
		end
	end

	vfs_avg_filter #(
		.WIDTH(COUNT_W)
	) u_avg (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_step(i_sense_step),
		.i_freeze(freeze),
		.i_sample(i_touch_counts),
		.i_beta(beta),
		.o_average(avg)
	);

	always_comb begin
		delta_up = {1'b0, i_touch_counts} - {1'b0, avg};
		delta_down = {1'b0, avg} - {1'b0, i_touch_counts};
		release_thr = direction_rev ? i_reverse_release_threshold
			: i_forward_release_threshold;
		// Freewheel thresholds replace the plain touch threshold
		touch_thr = fw_mode ? i_stop_touch_threshold : i_touch_threshold;
		// Release: counts above average by more than threshold
		release_hit = (i_touch_counts > avg)
			&& (delta_up[COUNT_W-1:0] > release_thr) && !touch_dir;
		touch_hit = (i_touch_counts < avg)
			&& (delta_down[COUNT_W-1:0] > touch_thr);
		// Sudden rise in counts since the last sensing step also counts as release
		if (i_touch_counts > prev_counts) begin
			if (COUNT_W'(i_touch_counts - prev_counts) > release_thr) begin
				release_hit = 1'b1;
			end
		end
	end

	always_comb begin
		decay = {1'b0, speed >> i_inertia} + {1'b0, speed >> i_damping};
		decay_total = {1'b0, decay} + {2'b00, i_friction};
		phase_sum = {1'b0, phase} + {1'b0, speed};
		next_state = state;
		next_speed = speed;
		next_direction_rev = direction_rev;
		next_fast_phase = fast_phase;
		next_phase = phase;
		next_touch_dir = touch_dir;
		next_touch_act = touch_act;
		next_rel_evt = 1'b0;
		next_int_pulse = 1'b0;
		next_int_rev = int_rev;
		next_quad = quad;
		next_prev_counts = prev_counts;
		if (!fw_mode) begin
			next_int_pulse = i_magnet_interval;
			next_int_rev = i_magnet_reverse;
		end
		if (i_sense_step) begin
			next_prev_counts = i_touch_counts;
			next_touch_dir = i_touch_counts < avg;
			next_touch_act = touch_hit;
			if (touch_hit || release_hit) begin
				next_fast_phase = 1'b1;
			end else if (delta_up[COUNT_W-1:0] < touch_thr
				&& delta_down[COUNT_W-1:0] < touch_thr) begin
				next_fast_phase = 1'b0;
			end
			next_rel_evt = release_hit;
			case (state)
				VFS_IDLE, VFS_TOUCHED: begin
					next_direction_rev = i_magnet_reverse;
					next_state = touch_hit ? VFS_TOUCHED : VFS_IDLE;
					if (fw_mode && release_hit
						&& i_magnet_speed > i_min_start_speed) begin
						next_state = VFS_FREEWHEEL;
						next_speed = i_magnet_speed;
						next_phase = PHASE_RESET;
					end
				end
				VFS_FREEWHEEL: begin
					if (decay_total > {2'b00, speed}) begin
						next_speed = SPEED_RESET;
					end else begin
						next_speed = SPEED_W'({2'b00, speed} - decay_total);
					end
					if (touch_hit || !fw_mode) begin
						next_state = VFS_TOUCHED;
						next_speed = SPEED_RESET;
					end else if (speed < i_stop_speed) begin
						next_state = VFS_IDLE;
						next_speed = SPEED_RESET;
					end else begin
						// Phase wrap makes one simulated interval
						next_phase = phase_sum[PHASE_W-1:0];
						if (phase_sum[PHASE_W]) begin
							next_int_pulse = 1'b1;
							next_int_rev = direction_rev;
						end
					end
				end
				default: begin
					next_state = VFS_IDLE;
				end
			endcase
		end
		if (next_int_pulse) begin
			// Gray step of the quadrature pair
			if (next_int_rev) begin
				next_quad = {quad[0], ~quad[1]};
			end else begin
				next_quad = {~quad[0], quad[1]};
			end
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= VFS_IDLE;
			speed <= SPEED_RESET;
			direction_rev <= 1'b0;
			fast_phase <= 1'b0;
			phase <= PHASE_RESET;
			touch_dir <= 1'b0;
			touch_act <= 1'b0;
			rel_evt <= 1'b0;
			int_pulse <= 1'b0;
			int_rev <= 1'b0;
			quad <= QUAD_RESET;
			prev_counts <= COUNT_RESET;
		end else begin
			state <= next_state;
			speed <= next_speed;
			direction_rev <= next_direction_rev;
			fast_phase <= next_fast_phase;
			phase <= next_phase;
			touch_dir <= next_touch_dir;
			touch_act <= next_touch_act;
			rel_evt <= next_rel_evt;
			int_pulse <= next_int_pulse;
			int_rev <= next_int_rev;
			quad <= next_quad;
			prev_counts <= next_prev_counts;
		end
	end

	assign o_long_term_average = avg;
	assign o_touch_direction = touch_dir;
	assign o_touch_active = touch_act;
	assign o_release_event = rel_evt;
	assign o_freewheel_active = state == VFS_FREEWHEEL;
	assign o_freewheel_speed = speed;
	assign o_interval_pulse = int_pulse;
	assign o_interval_reverse = int_rev;
	assign o_quadrature = quad;

	sequence s_start;
		i_sense_step && fw_mode && release_hit && state != VFS_FREEWHEEL
			&& i_magnet_speed > i_min_start_speed;
	endsequence
	a_start_loads_speed: assert property (@(posedge i_mclk)
		disable iff (!rst_n) s_start |=> o_freewheel_active
		&& speed == $past(i_magnet_speed))
		else $error("freewheel did not start with magnet speed");
	a_start_needs_speed: assert property (@(posedge i_mclk)
		disable iff (!rst_n) !o_freewheel_active ##1 o_freewheel_active
		|-> $past(i_magnet_speed) > $past(i_min_start_speed))
		else $error("freewheel started below minimum speed");
	a_touch_stops: assert property (@(posedge i_mclk)
		disable iff (!rst_n) o_freewheel_active && i_sense_step && touch_hit
		|=> !o_freewheel_active)
		else $error("touch did not stop freewheel");
	a_slow_stops: assert property (@(posedge i_mclk)
		disable iff (!rst_n) o_freewheel_active && i_sense_step
		&& speed < i_stop_speed |=> !o_freewheel_active)
		else $error("freewheel kept running below stop speed");
	a_speed_decays: assert property (@(posedge i_mclk)
		disable iff (!rst_n) o_freewheel_active ##1 o_freewheel_active
		|-> speed <= $past(speed))
		else $error("simulated speed rose");
	a_two_way_forced: assert property (@(posedge i_mclk)
		disable iff (!rst_n) i_freewheel_enable |-> o_two_way_active)
		else $error("two-way sensing not forced");
	a_direction_flag: assert property (@(posedge i_mclk)
		disable iff (!rst_n) i_sense_step |=> o_touch_direction
		== ($past(i_touch_counts) < $past(avg)))
		else $error("direction flag wrong");
	a_pulse_quad: assert property (@(posedge i_mclk)
		disable iff (!rst_n) o_interval_pulse |-> o_quadrature
		!= $past(o_quadrature))
		else $error("interval pulse without quadrature step");
	a_no_freeze: assert property (@(posedge i_mclk)
		disable iff (!rst_n) i_release_detect_mode |-> !freeze)
		else $error("average frozen in release mode");
endmodule : vfs_freewheel

// ==== dv/vfs_host_model.sv ====
// Host side model: counts interval pulses and checks quadrature steps
module vfs_host_model (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_interval_pulse,
	input wire logic [1:0] i_quadrature,
	output int o_pulse_count,
	output int o_gray_errors
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] last_quad;
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pulse_count <= 0;
			o_gray_errors <= 0;
			last_quad <= 2'h0;
		end else begin
			if (i_interval_pulse === 1'b1) begin
				o_pulse_count <= o_pulse_count + 1;
			end
			if ($countones(i_quadrature ^ last_quad) > 1) begin
				o_gray_errors <= o_gray_errors + 1;
			end
			last_quad <= i_quadrature;
		end
	end
endmodule // vfs_host_model

// ==== dv/tb_virtual_freewheel_scroll.sv ====
// Self-checking bench for the virtual freewheel scroll block
module tb_virtual_freewheel_scroll;
	timeunit 1ns;
	timeprecision 1ps;
	import vfs_pkg::*;
	localparam int MIN = 512;
	localparam int STOP = 256;
	localparam int REV = 20;
	localparam int TSTOP = 8;
	logic i_mclk, i_reset_n, i_sense_step, i_magnet_reverse;
	logic i_freewheel_enable, i_two_way_touch_sensing;
	logic i_magnet_interval, i_forced_hall_freewheel, i_release_detect_mode;
	logic [15:0] i_min_start_speed, i_stop_speed;
	logic [15:0] i_touch_counts, i_magnet_speed, i_friction;
	logic [15:0] i_forward_release_threshold;
	logic [3:0] i_inertia, i_damping;
	logic [15:0] avg, spd;
	logic dir, touch, rel, two_way, act, ipulse, irev;
	logic [1:0] quad;
	int error_cnt, cmp_count, cycles, seed, pulses, gerr;
	int m_act, m_spd, m_prev, m_ev;
	int m_avg, m_thr, m_tch, m_dir, m_rev, m_phase, m_pulses;
	longint m_acc;
	vfs_freewheel dut (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sense_step(i_sense_step),
		.i_touch_counts(i_touch_counts), .i_magnet_speed(i_magnet_speed),
		.i_magnet_reverse(i_magnet_reverse),
		.i_magnet_interval(i_magnet_interval),
		.i_freewheel_enable(i_freewheel_enable),
		.i_forced_hall_freewheel(i_forced_hall_freewheel),
		.i_release_detect_mode(i_release_detect_mode),
		.i_two_way_touch_sensing(i_two_way_touch_sensing),
		.i_slow_average_coefficient(4'h4),
		.i_fast_average_coefficient(4'h4),
		.i_touch_threshold(16'h0001),
		.i_forward_release_threshold(i_forward_release_threshold),
		.i_reverse_release_threshold(16'h0014),
		.i_stop_touch_threshold(16'h0008),
		.i_min_start_speed(i_min_start_speed),
		.i_stop_speed(i_stop_speed), .i_inertia(i_inertia),
		.i_friction(i_friction), .i_damping(i_damping),
		.o_long_term_average(avg), .o_touch_direction(dir),
		.o_touch_active(touch), .o_release_event(rel),
		.o_two_way_active(two_way), .o_freewheel_active(act),
		.o_freewheel_speed(spd), .o_interval_pulse(ipulse),
		.o_interval_reverse(irev), .o_quadrature(quad));
	vfs_host_model host (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_interval_pulse(ipulse), .i_quadrature(quad),
		.o_pulse_count(pulses), .o_gray_errors(gerr));
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 10000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic rst();
		i_reset_n <= 1'b0;
		repeat (8) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_mclk);
		m_act = 0;
		m_spd = 0;
		m_prev = 0;
		m_acc = 0;
		m_rev = 0;
		m_dir = 0;
		m_tch = 0;
		m_ev = 0;
		m_phase = 0;
		m_pulses = 0;
	endtask
	// One sensing step, then the model's step and the comparison
	task automatic go(input int c, input int ms);
		@(posedge i_mclk);
		i_touch_counts <= c[15:0];
		i_magnet_speed <= ms[15:0];
		i_sense_step <= 1'b1;
		@(posedge i_mclk);
		i_sense_step <= 1'b0;
		#1;
		m_avg = int'(m_acc >>> 15);
		m_thr = (m_rev != 0) ? REV : int'(i_forward_release_threshold);
		m_ev = int'((c - m_prev > m_thr)
			|| (c - m_avg > m_thr && m_dir == 0));
		m_tch = int'(m_avg - c > TSTOP);
		if (m_act != 0) begin
			if (m_tch != 0 || m_spd < STOP) begin
				m_act = 0;
				m_spd = 0;
			end else begin
				m_phase += m_spd;
				if (m_phase > 65535) begin
					m_phase -= 65536;
					m_pulses++;
				end
				m_spd -= (m_spd >> i_inertia) + (m_spd >> i_damping)
					+ int'(i_friction);
				if (m_spd < 0) m_spd = 0;
			end
		end else begin
			m_rev = int'(i_magnet_reverse);
			if (m_ev != 0 && ms > MIN) begin
				m_act = 1;
				m_spd = ms;
				m_phase = 0;
			end
		end
		m_dir = int'(c < m_avg);
		m_prev = c;
		m_acc = m_acc - (m_acc >>> 4) + (longint'(c) <<< 11);
		m_avg = int'(m_acc >>> 15);
		check(act, m_act[15:0]);
		check(rel, m_ev[15:0]);
		check(touch, m_tch[15:0]);
		check(dir, m_dir[15:0]);
		check(avg, m_avg[15:0]);
		if (m_act != 0) check(spd, m_spd[15:0]);
	endtask
	initial begin
		seed = 52;
		i_reset_n = 1'b0;
		i_sense_step = 1'b0;
		i_magnet_reverse = 1'b0;
		i_freewheel_enable = 1'b1;
		i_forced_hall_freewheel = 1'b1;
		i_release_detect_mode = 1'b1;
		i_magnet_interval = 1'b0;
		i_min_start_speed = 16'h0200;
		i_stop_speed = 16'h0100;
		i_two_way_touch_sensing = 1'b0;
		i_touch_counts = 16'h0000;
		i_magnet_speed = 16'h0000;
		i_friction = 16'h0010;
		i_forward_release_threshold = 16'h0800;
		i_inertia = 4'h4;
		i_damping = 4'h6;
		rst();
		repeat (150) go(1000, 0);
		go(2000, 16'h4000);
		repeat (150) go(1000, 0);
		@(posedge i_mclk);
		i_magnet_reverse <= 1'b1;
		go(1000, 0);
		go(2000, MIN);
		repeat (150) go(1000, 0);
		go(2000, 16'h2000 + ($random(seed) & 16'h1FFF));
		repeat (5) @(posedge i_mclk);
		check(spd, m_spd[15:0]);
		repeat (120) go(2000, 0);
		check(16'(pulses > 0), 16'h0001);
		check(16'(pulses), m_pulses[15:0]);
		check(16'(irev), 16'h0001);
		check(16'(gerr), 16'h0000);
		repeat (150) go(1000, 0);
		@(posedge i_mclk);
		i_magnet_reverse <= 1'b0;
		i_forward_release_threshold <= 16'h0014;
		i_inertia <= 4'h3;
		i_damping <= 4'h4 + 4'($random(seed) & 3);
		i_friction <= 16'($random(seed) & 16'h001F);
		go(2000, 16'h2000 + ($random(seed) & 16'h1FFF));
		repeat (3) go(2000, 0);
		go(100, 0);
		check(16'(dir), 16'h0001);
		repeat (100) go(100, 0);
		check(16'(avg < 16'h0100), 16'h0001);
		@(posedge i_mclk);
		i_freewheel_enable <= 1'b0;
		@(posedge i_mclk);
		#1;
		check(16'(two_way), 16'h0000);
		@(posedge i_mclk);
		i_freewheel_enable <= 1'b1;
		@(posedge i_mclk);
		#1;
		check(16'(two_way), 16'h0001);
		repeat (150) go(1000, 0);
		go(2000, MIN + 1 + ($random(seed) & 16'h3FFF));
		rst();
		check(16'(act), 16'h0000);
		check(spd, 16'h0000);
		repeat (2) go(1000, 0);
		end_sim();
	end
endmodule // tb_virtual_freewheel_scroll
